// File: dv/i2c_eeprom_sensor_slave_test.sv
// i2c_eeprom_sensor_slave_test.sv: bench for iess_top
// assumes iess_master as partner, short limits
`timescale 1ns/100ps
`default_nettype none

module i2c_eeprom_sensor_slave_test;
    import iess_pkg::*;
    localparam logic ACK  = 1'b0;
    localparam logic NACK = 1'b1;

    logic              clk;
    logic              rst;
    logic              scl;
    logic              m_oe;
    logic              sda_out;
    logic              sda_oe;
    logic              conv;
    logic              busy;
    logic              s_valid;
    logic              s_ready;
    logic [2:0]        pins;
    logic [7:0]        s_ptr;
    logic [15:0]       s_rd;
    logic [SENS_W-1:0] s_data;
    logic [7:0]        obs_q [$];
    logic [7:0]        img [16];
    logic [7:0]        bus_q [$];
    logic [SENS_W-1:0] sens_q [$];
    int                err_count;
    int                samples_checked;
    event              obs_ev;
    wire logic         sda;

    assign sda = !(sda_oe | m_oe);

    iess_master u_mst (.clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe));

    iess_top #(.LOW_LIMIT_CYC(TO_W'(200)), .WR_CYCLE_CYCLES(WR_W'(600))) u_dut (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_select_pin_zero(pins[0]), .addr_select_pin_one(pins[1]),
        .addr_select_pin_two(pins[2]), .sensor_conv_mode(conv), .nvm_busy(busy),
        .sens_rd_ptr(s_ptr), .sens_rd_data(s_rd), .sens_wr_valid(s_valid),
        .sens_wr_data(s_data), .sens_wr_ready(s_ready)
    );

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic note(input logic [7:0] seen, input logic [7:0] exp);
        bus_q.push_back(exp);
        obs_q.push_back(seen);
        ->obs_ev;
    endtask

    task automatic wb(input logic [7:0] d, input logic a);
        logic s;
        u_mst.wbyte(d, s);
        note({7'h0, s}, {7'h0, a});
    endtask

    task automatic rb(input logic [7:0] e, input logic last);
        logic [7:0] d;
        u_mst.rbyte(d, last);
        note(d, e);
    endtask

    function automatic logic [7:0] adr(input logic [3:0] p, input logic [2:0] a, input logic r);
        return {p, a, r};
    endfunction

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial forever begin
        @(obs_ev);
        while (obs_q.size() != 0)
            check("bus value", 24'(obs_q.pop_front()), 24'(bus_q.pop_front()));
    end

    always @(posedge clk) begin
        if (s_valid === 1'b1 && s_ready === 1'b1) begin
            check("sensor word", s_data, sens_q.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        results();
    end

    initial begin
        logic [23:0] w;
        rst = 1'b1;
        pins = 3'h0;
        s_ready = 1'b0;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(32'h94a093cf));
        s_rd = {1'b0, 15'($urandom)};
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        pins = 3'($urandom);
        u_mst.hp(2);
        note({7'h0, conv}, 8'h01);
        note(s_ptr, PTR_RESET);
        u_mst.start();
        wb(adr(PRE_MEMORY, pins, 1'b1), ACK);
        rb(MEM_ERASED, NACK);
        u_mst.stop();
        $display("test reset_state done");
        u_mst.low();
        wb(adr(PRE_MEMORY, pins, 1'b0), NACK);
        u_mst.stop();
        for (int i = 0; i < 8; i++) begin
            u_mst.start();
            wb(adr(i == 0 ? 4'h6 : PRE_MEMORY, pins ^ 3'(i), 1'b0), NACK);
            u_mst.stop();
        end
        $display("test address_refusal done");
        u_mst.start();
        wb(adr(PRE_MEMORY, pins, 1'b0), ACK);
        u_mst.hp(400);
        wb(8'h5e, ACK);
        for (int i = 0; i < 18; i++) begin
            w[7:0] = 8'($urandom);
            img[4'(14 + i)] = w[7:0];
            wb(w[7:0], ACK);
        end
        u_mst.stop();
        u_mst.start();
        wb(adr(PRE_MEMORY, pins, 1'b0), NACK);
        u_mst.stop();
        for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge clk);
        #1;
        note({7'h0, busy}, 8'h00);
        u_mst.start();
        wb(adr(PRE_MEMORY, pins, 1'b0), ACK);
        wb(8'h50, ACK);
        u_mst.start();
        wb(adr(PRE_MEMORY, pins, 1'b1), ACK);
        for (int i = 0; i < 16; i++) rb(img[i], i == 15);
        u_mst.stop();
        $display("test page_write done");
        for (int k = 0; k < 3; k++) begin
            u_mst.start();
            wb(adr(PRE_SENSOR, pins, 1'b0), k == 2 ? NACK : ACK);
            if (k < 2) begin
                w = 24'($urandom);
                sens_q.push_back(w);
                wb(w[23:16], ACK);
                wb(w[15:8], ACK);
                wb(w[7:0], ACK);
            end
            u_mst.stop();
        end
        s_ready = 1'b1;
        for (int n = 0; n < 50 && sens_q.size() != 0; n++) @(posedge clk);
        #1;
        note(8'(sens_q.size()), 8'h00);
        $display("test sensor_write done");
        s_rd = {1'b0, 15'($urandom)};
        u_mst.start();
        wb(adr(PRE_SENSOR, pins, 1'b1), ACK);
        u_mst.hp(150);
        note({7'h0, sda_oe}, 8'h01);
        u_mst.hp(150);
        note({7'h0, sda_oe}, 8'h00);
        u_mst.stop();
        $display("test clock_low_limit done");
        rst = 1'b1;
        u_mst.hp(8);
        note({conv, sda_oe, busy, s_valid, 4'h0}, 8'h00);
        note(s_ptr, PTR_RESET);
        rst = 1'b0;
        u_mst.hp(2);
        note({7'h0, conv}, 8'h01);
        $display("test second_reset done");
        #1;
        results();
    end
endmodule

`default_nettype wire

// File: dv/iess_assertions.sv
// iess_assertions.sv: port checker
// assumes it is bound to iess_top and bus phases last at least 8 clk
`timescale 1ns/100ps
`default_nettype none

module iess_assertions
    import iess_pkg::*;
#(
    parameter logic [TO_W-1:0] LOW_LIMIT_CYC   = TO_W'(CLK_LOW_LIMIT_CYC),
    parameter logic [WR_W-1:0] WR_CYCLE_CYCLES = WR_W'(WR_CYCLE_CYC)
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    input wire logic              addr_select_pin_zero,
    input wire logic              addr_select_pin_one,
    input wire logic              addr_select_pin_two,
    input wire logic              sensor_conv_mode,
    input wire logic              nvm_busy,
    input wire logic [7:0]        sens_rd_ptr,
    input wire logic [15:0]       sens_rd_data,
    input wire logic              sens_wr_valid,
    input wire logic [SENS_W-1:0] sens_wr_data,
    input wire logic              sens_wr_ready
);
    // 35/25 of limit plus pin latency
    localparam int TO_MAX = int'(LOW_LIMIT_CYC) * 7 / 5 + 8;

    int              low_cnt;
    logic [WR_W-1:0] busy_cnt;
    logic            sda_q;
    logic            start_seen;

    default clocking cb @(posedge clk); endclocking

    always_ff @(posedge clk) begin
        if (rst || scl_in) begin
            low_cnt <= 0;
        end else if (low_cnt < TO_MAX) begin
            low_cnt <= low_cnt + 1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !nvm_busy) begin
            busy_cnt <= '0;
        end else begin
            busy_cnt <= busy_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        sda_q <= sda_in;
        if (rst) begin
            start_seen <= 1'b0;
        end else if (scl_in && sda_q && !sda_in) begin
            start_seen <= 1'b1;
        end
    end

    a_drive_is_low: assert property (disable iff (rst) sda_oe |-> !sda_out)
        else $error("data driven high");
    a_oe_rise_low: assert property (disable iff (rst)
        $rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("drive changed, clock high");
    a_reset_idle: assert property (rst |=> !sda_oe && !nvm_busy && !sens_wr_valid
        && !sensor_conv_mode && sens_rd_ptr == PTR_RESET)
        else $error("not idle in reset");
    a_conv_after_rst: assert property ($fell(rst) |=> sensor_conv_mode)
        else $error("no conversion after reset");
    a_conv_stays: assert property (!rst && !$past(rst) |-> sensor_conv_mode)
        else $error("conversion mode dropped");
    a_busy_length: assert property (disable iff (rst)
        $fell(nvm_busy) |-> busy_cnt == WR_CYCLE_CYCLES)
        else $error("write cycle length wrong");
    a_sens_hold: assert property (disable iff (rst) sens_wr_valid && !sens_wr_ready
        |=> sens_wr_valid && $stable(sens_wr_data))
        else $error("stalled word changed");
    a_low_release: assert property (disable iff (rst) low_cnt == TO_MAX |-> !sda_oe)
        else $error("data held past clock-low limit");
    a_drive_after_start: assert property (disable iff (rst) $rose(sda_oe) |-> start_seen)
        else $error("drive before any start");
    a_stop_release: assert property (disable iff (rst)
        scl_in && !sda_q && sda_in |-> ##[1:8] !sda_oe)
        else $error("data held after stop");
endmodule

bind iess_top iess_assertions #(
    .LOW_LIMIT_CYC  (LOW_LIMIT_CYC),
    .WR_CYCLE_CYCLES(WR_CYCLE_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_pin_zero(addr_select_pin_zero),
    .addr_select_pin_one(addr_select_pin_one), .addr_select_pin_two(addr_select_pin_two),
    .sensor_conv_mode(sensor_conv_mode), .nvm_busy(nvm_busy), .sens_rd_ptr(sens_rd_ptr),
    .sens_rd_data(sens_rd_data), .sens_wr_valid(sens_wr_valid),
    .sens_wr_data(sens_wr_data), .sens_wr_ready(sens_wr_ready)
);

`default_nettype wire

// File: dv/iess_master.sv
// iess_master.sv: behavioural bus master
// assumes the bench wires data from both enables
`timescale 1ns/100ps
`default_nettype none

module iess_master (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic m_oe
);
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end

    task automatic hp(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic start();
        m_oe = 1'b0;
        hp(10);
        scl = 1'b1;
        hp(10);
        m_oe = 1'b1;
        hp(10);
        scl = 1'b0;
        hp(10);
    endtask

    task automatic stop();
        m_oe = 1'b1;
        hp(10);
        scl = 1'b1;
        hp(10);
        m_oe = 1'b0;
        hp(20);
    endtask

    task automatic low();
        scl = 1'b0;
        hp(10);
    endtask

    // data moves while clock low
    task automatic bit_io(input logic b, output logic s);
        m_oe = !b;
        hp(10);
        scl = 1'b1;
        hp(5);
        s = sda;
        hp(5);
        scl = 1'b0;
        hp(2);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, a);
    endtask

    task automatic rbyte(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(nack, s);
    endtask
endmodule

`default_nettype wire

// File: hdl/iess_fifo2.sv
// iess_fifo2.sv: two-entry buffer, outputs held in flip-flops
// assumes push and pop streams share clk
`timescale 1ns/100ps
`default_nettype none

module iess_fifo2 #(
    parameter int W = 8
) (
    input  wire logic    clk,
    input  wire logic    rst,
    iess_stream_if.snk   in_s,
    iess_stream_if.src   out_s
);
    logic         v0;
    logic         v1;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic         push;
    logic         pop;

    assign in_s.ready  = ~v1;
    assign out_s.valid = v0;
    assign out_s.data  = d0;
    assign push        = in_s.valid & ~v1;
    assign pop         = v0 & out_s.ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            v0 <= 1'b0;
            v1 <= 1'b0;
            d0 <= '0;
            d1 <= '0;
        end else if (pop && push) begin
            d0 <= in_s.data;
        end else if (pop) begin
            d0 <= d1;
            v0 <= v1;
            v1 <= 1'b0;
        end else if (push) begin
            if (v0) begin
                d1 <= in_s.data;
                v1 <= 1'b1;
            end else begin
                d0 <= in_s.data;
                v0 <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// File: hdl/iess_pkg.sv
// iess_pkg.sv: constants and types of the slave
// assumes one 40 MHz clock
`default_nettype none

package iess_pkg;

    localparam int CLK_HZ            = 40_000_000;

    // 25..35 ms window, rounds up
    localparam int CLK_LOW_LIMIT_MS  = 25;
    localparam int CLK_LOW_LIMIT_CYC = (CLK_LOW_LIMIT_MS * CLK_HZ + 999) / 1000;
    localparam int TO_W              = 20;

    // write cycle, rounds down
    localparam int WR_CYCLE_MS       = 5;
    localparam int WR_CYCLE_CYC      = (WR_CYCLE_MS * CLK_HZ) / 1000;
    localparam int WR_W              = 18;

    localparam logic [3:0] PRE_SENSOR = 4'h3;
    localparam logic [3:0] PRE_MEMORY = 4'ha;

    localparam int PAGE_BYTES = 16;
    localparam int MEM_BYTES  = 256;

    localparam logic [7:0]  MEM_ERASED  = 8'hff;
    localparam logic [7:0]  PTR_RESET   = 8'h00;
    localparam logic [3:0]  BIT_LAST    = 4'h8;
    localparam logic [1:0]  IDX_ADDR    = 2'h0;
    localparam logic [1:0]  IDX_PTR     = 2'h1;
    localparam logic [1:0]  IDX_DATA_HI = 2'h2;
    localparam logic [1:0]  IDX_DATA_LO = 2'h3;

    // sensor word: {pointer, value}
    localparam int SENS_W = 24;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RX   = 5'b00010,
        S_ACK  = 5'b00100,
        S_TX   = 5'b01000,
        S_MACK = 5'b10000
    } iess_state_t;

endpackage

`default_nettype wire

// File: hdl/iess_stream_if.sv
// iess_stream_if.sv: valid/ready word stream
// assumes one clock at both ends
`timescale 1ns/100ps
`default_nettype none

interface iess_stream_if #(
    parameter int W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

`default_nettype wire

// File: hdl/iess_sync.sv
// iess_sync.sv: three-stage pin synchroniser
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none

module iess_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output var  logic [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level <= '1;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: hdl/iess_top.sv
// iess_top.sv: two-wire slave for sensor registers and page memory
// assumes raw bus pins; sensor registers live outside on clk
//
// Functional notes
// - sensor: long clock low resets protocol, releases data
// - clock-low counter restarts on each clock fall in a frame
// - memory never times out
// - sample on clock rise, change drive after clock fall
// - reset: sensor converts after, memory idles
// - zero pulls data low, one releases
// - start: data fall, clock high; idle until start
// - stop: data rise, clock high; ends command
// - preamble 0011 sensor, 1010 memory
// - three address bits match select pins
// - last address bit: 1 read, 0 write
// - ack matching address (sensor write only while buffer has room) and each written byte
// - when sending, stop after master nack
// - write: address, location, data bytes (two for sensor, any count for memory)
// - stop commits sensor write or starts memory cycle
// - location: upper nibble page, lower nibble byte
// - in-page counter wraps within page
// - write cycle after stop, latest byte per position
// - no address ack during memory write cycle
// - memory resets to 0xff, no write lock
// - clock-low limit fires within 25 to 35 ms
// - pointers reset to 00h
`timescale 1ns/100ps
`default_nettype none

module iess_top
    import iess_pkg::*;
#(
    parameter logic [TO_W-1:0] LOW_LIMIT_CYC   = TO_W'(CLK_LOW_LIMIT_CYC),
    parameter logic [WR_W-1:0] WR_CYCLE_CYCLES = WR_W'(WR_CYCLE_CYC)
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output var  logic              sda_out,
    output var  logic              sda_oe,
    input  wire logic              addr_select_pin_zero,
    input  wire logic              addr_select_pin_one,
    input  wire logic              addr_select_pin_two,
    output var  logic              sensor_conv_mode,
    output var  logic              nvm_busy,
    output var  logic [7:0]        sens_rd_ptr,
    input  wire logic [15:0]       sens_rd_data,
    output logic                   sens_wr_valid,
    output logic [SENS_W-1:0]      sens_wr_data,
    input  wire logic              sens_wr_ready
);

    logic [1:0]       bus_lv;
    logic [2:0]       pin_lv;
    logic             scl_s;
    logic             sda_s;
    logic             scl_q;
    logic             sda_q;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_det;
    logic             stop_det;

    iess_state_t      state;
    logic             in_frame;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic [1:0]       bytecnt;
    logic             sel_mem;
    logic             sel_sens;
    logic             rd;
    logic [7:0]       txbyte;
    logic [7:0]       tx_next;
    logic             tx_half;

    logic [TO_W-1:0]  to_cnt;
    logic             to_fire;

    logic             pre_mem;
    logic             pre_sens;
    logic             pins_ok;
    logic             addr_ok;
    logic             rx_byte;
    logic             tx_load;

    logic [7:0]       mem_ptr;
    logic [15:0]      sens_data;
    logic             sens_pend;

    logic             pg_clear;
    logic             pg_write;
    logic [3:0]       page_num;
    logic [15:0]      page_mask;
    logic [7:0]       page_buf [PAGE_BYTES];
    logic [7:0]       mem      [MEM_BYTES];
    logic [WR_W-1:0]  wr_cnt;

    iess_stream_if #(.W(SENS_W)) push_s ();
    iess_stream_if #(.W(SENS_W)) pop_s ();

    // pin synchronisers
    iess_sync #(.W(2)) u_bus_sync (
        .clk   (clk),
        .rst   (rst),
        .pin   ({scl_in, sda_in}),
        .level (bus_lv)
    );

    iess_sync #(.W(3)) u_pin_sync (
        .clk   (clk),
        .rst   (rst),
        .pin   ({addr_select_pin_two, addr_select_pin_one, addr_select_pin_zero}),
        .level (pin_lv)
    );

    assign scl_s = bus_lv[1];
    assign sda_s = bus_lv[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // frame tracking for the clock-low counter
    always_ff @(posedge clk) begin
        if (rst) begin
            in_frame <= 1'b0;
        end else if (start_det) begin
            in_frame <= 1'b1;
        end else if (stop_det || to_fire) begin
            in_frame <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || scl_fall || !in_frame) begin
            to_cnt <= '0;
        end else if (!scl_s && to_cnt != LOW_LIMIT_CYC) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // limit applies to sensor only
    assign to_fire = sel_sens && (to_cnt == LOW_LIMIT_CYC);

    // address decode
    assign pre_mem  = (shreg[7:4] == PRE_MEMORY);
    assign pre_sens = (shreg[7:4] == PRE_SENSOR);
    assign pins_ok  = (shreg[3:1] == pin_lv);
    assign addr_ok  = pins_ok && ((pre_mem && !nvm_busy)
                               || (pre_sens && (shreg[0] || push_s.ready)));

    assign rx_byte = (state == S_RX) && scl_fall && (bitcnt == BIT_LAST);
    assign tx_load = scl_fall && (((state == S_ACK) && rd) || (state == S_MACK));

    always_comb begin
        if (sel_mem) begin
            tx_next = mem[mem_ptr];
        end else if (tx_half) begin
            tx_next = sens_rd_data[7:0];
        end else begin
            tx_next = sens_rd_data[15:8];
        end
    end

    // protocol sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= S_IDLE;
            bitcnt   <= '0;
            shreg    <= '0;
            bytecnt  <= IDX_ADDR;
            sel_mem  <= 1'b0;
            sel_sens <= 1'b0;
            rd       <= 1'b0;
            sda_oe   <= 1'b0;
            txbyte   <= '0;
        end else if (start_det) begin
            state    <= S_RX;
            bitcnt   <= '0;
            bytecnt  <= IDX_ADDR;
            sel_mem  <= 1'b0;
            sel_sens <= 1'b0;
            rd       <= 1'b0;
            sda_oe   <= 1'b0;
        end else if (stop_det || to_fire) begin
            state    <= S_IDLE;
            sel_mem  <= 1'b0;
            sel_sens <= 1'b0;
            sda_oe   <= 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    sda_oe <= 1'b0;
                end
                S_RX: begin
                    if (scl_rise && bitcnt != BIT_LAST) begin
                        shreg  <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 1'b1;
                    end else if (rx_byte) begin
                        if (bytecnt != IDX_DATA_LO) begin
                            bytecnt <= bytecnt + 1'b1;
                        end
                        if (bytecnt != IDX_ADDR || addr_ok) begin
                            sda_oe <= 1'b1;
                            state  <= S_ACK;
                            if (bytecnt == IDX_ADDR) begin
                                sel_mem  <= pre_mem;
                                sel_sens <= ~pre_mem;
                                rd       <= shreg[0];
                            end
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        if (rd) begin
                            txbyte <= tx_next;
                            sda_oe <= ~tx_next[7];
                            bitcnt <= 4'h1;
                            state  <= S_TX;
                        end else begin
                            sda_oe <= 1'b0;
                            bitcnt <= '0;
                            state  <= S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == BIT_LAST) begin
                            sda_oe <= 1'b0;
                            state  <= S_MACK;
                        end else begin
                            txbyte <= {txbyte[6:0], 1'b0};
                            sda_oe <= ~txbyte[6];
                            bitcnt <= bitcnt + 1'b1;
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise && sda_s) begin
                        state <= S_IDLE;
                    end else if (scl_fall) begin
                        txbyte <= tx_next;
                        sda_oe <= ~tx_next[7];
                        bitcnt <= 4'h1;
                        state  <= S_TX;
                    end
                end
                default: begin
                    state  <= S_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // pointers and sensor write staging
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_ptr   <= PTR_RESET;
            sens_rd_ptr <= PTR_RESET;
            sens_data <= '0;
            sens_pend <= 1'b0;
            tx_half   <= 1'b0;
        end else begin
            if (start_det || stop_det || to_fire) begin
                sens_pend <= 1'b0;
            end else if (rx_byte && !rd && sel_sens && bytecnt == IDX_DATA_LO) begin
                sens_pend <= 1'b1;
            end
            if (start_det) begin
                tx_half <= 1'b0;
            end else if (rx_byte && !rd && bytecnt == IDX_PTR) begin
                if (sel_mem) begin
                    mem_ptr <= shreg;
                end else begin
                    sens_rd_ptr <= shreg;
                    tx_half     <= 1'b0;
                end
            end else if (rx_byte && !rd && bytecnt != IDX_ADDR) begin
                if (sel_mem) begin
                    mem_ptr[3:0] <= mem_ptr[3:0] + 1'b1;
                end else if (bytecnt == IDX_DATA_HI) begin
                    sens_data[15:8] <= shreg;
                end else begin
                    sens_data[7:0] <= shreg;
                end
            end else if (tx_load) begin
                if (sel_mem) begin
                    mem_ptr <= mem_ptr + 1'b1;
                end else begin
                    tx_half <= ~tx_half;
                end
            end
        end
    end

    // sensor commit through the buffer
    assign push_s.valid = stop_det && sens_pend;
    assign push_s.data  = {sens_rd_ptr, sens_data};
    assign pop_s.ready  = sens_wr_ready;
    assign sens_wr_valid = pop_s.valid;
    assign sens_wr_data  = pop_s.data;

    iess_fifo2 #(.W(SENS_W)) u_fifo (
        .clk   (clk),
        .rst   (rst),
        .in_s  (push_s),
        .out_s (pop_s)
    );

    // page buffer and nonvolatile array
    assign pg_clear = rx_byte && !rd && sel_mem && (bytecnt == IDX_PTR);
    assign pg_write = rx_byte && !rd && sel_mem && (bytecnt[1] == 1'b1);

    always_ff @(posedge clk) begin
        if (rst) begin
            nvm_busy  <= 1'b0;
            wr_cnt    <= '0;
            page_num  <= '0;
            page_mask <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf[i] <= MEM_ERASED;
            end
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem[i] <= MEM_ERASED;
            end
        end else begin
            if (pg_clear) begin
                page_mask <= '0;
                page_num  <= shreg[7:4];
            end else if (pg_write) begin
                page_buf[mem_ptr[3:0]]  <= shreg;
                page_mask[mem_ptr[3:0]] <= 1'b1;
            end
            if (!nvm_busy && stop_det && (|page_mask)) begin
                nvm_busy <= 1'b1;
                wr_cnt   <= '0;
            end else if (nvm_busy) begin
                if (wr_cnt == WR_CYCLE_CYCLES - 1'b1) begin
                    nvm_busy  <= 1'b0;
                    page_mask <= '0;
                    for (int i = 0; i < PAGE_BYTES; i++) begin
                        if (page_mask[i]) begin
                            mem[{page_num, 4'(i)}] <= page_buf[i];
                        end
                    end
                end else begin
                    wr_cnt <= wr_cnt + 1'b1;
                end
            end
        end
    end

    // open-drain level low; conversion after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_out          <= 1'b0;
            sensor_conv_mode <= 1'b0;
        end else begin
            sda_out          <= 1'b0;
            sensor_conv_mode <= 1'b1;
        end
    end

endmodule

`default_nettype wire
